// ===== bench/fbr_host_model.sv
// Host memory controller model that drives the flash pins from the link clock.
// Assumes the device samples the pins on the rising link clock edge.
module fbr_host_model
(
	input  wire logic          link_clk,
	output fbr_pkg::fbr_pins_t pins
);
	timeunit 1ns;
	timeprecision 1ps;
	import fbr_pkg::*;

	initial pins = '{ce_n: 1'b1, oe_n: 1'b1, adv_n: 1'b1, addr: 20'h00000};

	// A deselected host does not park the address lines, so stale values cannot pass for good ones.
	task automatic idle(input int n);
		repeat (n)
		begin
			@(negedge link_clk);
			if (pins.ce_n)
				pins.addr = ~pins.addr;
		end
	endtask

	// The strobe is low for exactly one rising edge; a repeat call restarts the burst.
	task automatic start(input logic [ADDR_W-1:0] a);
		@(negedge link_clk);
		pins.ce_n = 1'b0;
		pins.oe_n = 1'b0;
		pins.adv_n = 1'b0;
		pins.addr = a;
		@(negedge link_clk);
		pins.adv_n = 1'b1;
		pins.addr = ~a;
	endtask

	task automatic set_sel(input logic ce_n, input logic oe_n);
		pins.ce_n = ce_n;
		pins.oe_n = oe_n;
	endtask
endmodule

// ===== bench/tb.sv
// Self-checking bench of the flash burst read engine and its configuration register.
// Assumes the array answers combinationally with a word made from its address.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fbr_pkg::*;

	logic                clock = 1'b0;
	logic                rst;
	logic                link_clk = 1'b0;
	logic                cfg_wr_valid;
	logic                algo_busy;
	logic                cfg_read_cmd;
	logic                cfg_read_bank;
	logic                cfg_read_exit;
	fbr_cfg_t            cfg_wr_data;
	fbr_cfg_t            cfg_rd_data;
	fbr_pins_t           pins;
	logic [ADDR_W-1:0]   array_rd_addr;
	logic [DATA_W-1:0]   array_rd_data;
	logic [DATA_W-1:0]   data_lines_o;
	logic                data_lines_oe;
	logic                flag_o;
	logic                flag_oe;
	logic [15:0]         cfg_m;
	logic [31:0]         r;
	int                  fails = 0;
	int                  num_checks = 0;
	int                  seed = 45;
	localparam logic [15:0] ASY [7] = '{16'h9CC3, 16'h1CC0, 16'h1CC4, 16'h1CC5, 16'h1CC6, 16'h1C43, 16'h1C83};

	assign array_rd_data = {12'hA5A, array_rd_addr};

	fbr_flash_burst uut (.clock(clock), .rst(rst), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_data(cfg_wr_data),
		.algo_busy(algo_busy), .cfg_read_cmd(cfg_read_cmd), .cfg_read_bank(cfg_read_bank),
		.cfg_read_exit(cfg_read_exit), .cfg_rd_data(cfg_rd_data), .link_clk(link_clk), .flash_pins(pins),
		.array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data), .data_lines_o(data_lines_o),
		.data_lines_oe(data_lines_oe), .end_of_burst_flag_n_o(flag_o), .end_of_burst_flag_n_oe(flag_oe));
	fbr_host_model host (.link_clk(link_clk), .pins(pins));

	initial forever #5 clock = ~clock;
	initial
	begin
		#7;
		forever #32 link_clk = ~link_clk;
	end

	function automatic logic [31:0] word(input logic [19:0] a);
		return {12'hA5A, a};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [15:0] d, input logic busy);
		@(negedge clock);
		cfg_wr_data = d;
		algo_busy = busy;
		cfg_wr_valid = 1'b1;
		@(negedge clock);
		cfg_wr_valid = 1'b0;
		algo_busy = 1'b0;
		if (!busy)
			cfg_m = d;
		chk({16'h0000, cfg_rd_data}, {16'h0000, cfg_m});
		host.idle(8);
	endtask

	task automatic asyn(input logic [19:0] a);
		host.start(a);
		host.idle(3);
		chk(data_lines_o, word(~a));
		chk({30'h0, data_lines_oe, flag_oe}, 32'h2);
		host.set_sel(1'b1, 1'b1);
	endtask

	// The queue holds the expected words in wrap order; one beat with output enable high is skipped.
	task automatic burst(input logic [19:0] a, input int n, input logic blip);
		int code;
		int len;
		int wc;
		logic [31:0] q[$];
		logic [31:0] e;
		code = cfg_m[13:10];
		len = 1 << cfg_m[2:0];
		wc = cfg_m[8];
		for (int b = 0; b < n; b++)
			q.push_back(word(20'((a & ~(len - 1)) | ((a + b) & (len - 1)))));
		host.start(a);
		for (int j = 1; j <= code; j++)
		begin
			@(negedge link_clk);
			chk({29'h0, data_lines_oe, flag_oe, flag_o}, 32'h3);
		end
		for (int b = 0; b < n; b++)
		begin
			@(negedge link_clk);
			host.set_sel(1'b0, 1'(blip && b == len));
			#1;
			e = q.pop_front();
			if (blip && b == len)
				chk({30'h0, data_lines_oe, flag_oe}, 32'h0);
			else
			begin
				chk(data_lines_o, e);
				chk({29'h0, data_lines_oe, flag_oe, flag_o}, {29'h3, 1'(b % len != len - 1 - wc)});
			end
		end
	endtask

	initial
	begin
		#200000;
		fails++;
		report_and_stop;
	end

	initial
	begin
		rst = 1'b1;
		cfg_wr_valid = 1'b0;
		cfg_read_cmd = 1'b0;
		cfg_read_exit = 1'b0;
		r = $random(seed);
		cfg_wr_data = r[15:0];
		algo_busy = r[16];
		cfg_read_bank = r[19];
		repeat (8) @(negedge clock);
		repeat (3) @(negedge link_clk);
		chk({16'h0000, cfg_rd_data}, {16'h0000, CFG_RESET});
		@(negedge clock);
		rst = 1'b0;
		cfg_m = CFG_RESET;
		host.idle(6);
		for (int k = 0; k < 7; k++)
		begin
			wr(ASY[k], 1'b0);
			r = $random(seed);
			asyn(r[19:0]);
		end
		r = $random(seed);
		wr(r[15:0], 1'b1);
		for (int i = 0; i < 14; i++)
		begin
			r = $random(seed);
			wr({2'b00, 4'(i % 7 + 1), 1'b0, r[3], 2'b11, 3'b000, 3'(i % 3 + 1)}, 1'b0);
			burst(r[31:12], 16, r[4]);
			host.set_sel(1'b1, 1'b0);
			host.idle(1);
			chk({30'h0, data_lines_oe, flag_oe}, 32'h0);
		end
		burst(20'h0ABC5, 3, 1'b0);
		burst(20'h03217, 16, 1'b0);
		host.set_sel(1'b1, 1'b1);
		@(negedge clock);
		cfg_read_bank = r[19];
		cfg_read_cmd = 1'b1;
		@(negedge clock);
		cfg_read_cmd = 1'b0;
		host.idle(8);
		host.start({r[19], 19'h00013});
		repeat (5)
		begin
			host.idle(1);
			chk(data_lines_o, {16'h0000, cfg_m});
			chk({31'h0, data_lines_oe}, 32'h1);
		end
		host.set_sel(1'b1, 1'b1);
		burst({~r[19], 19'h00013}, 8, 1'b0);
		@(negedge clock);
		cfg_read_exit = 1'b1;
		@(negedge clock);
		cfg_read_exit = 1'b0;
		host.start(20'h12345);
		host.idle(4);
		@(negedge clock);
		rst = 1'b1;
		host.idle(4);
		chk({14'h0, data_lines_oe, flag_oe, cfg_rd_data}, {16'h0000, CFG_RESET});
		@(negedge clock);
		rst = 1'b0;
		cfg_m = CFG_RESET;
		host.idle(6);
		asyn(20'h54321);
		report_and_stop;
	end
endmodule

// ===== shared/fbr_pkg.sv
// Shared types and constants of the flash linear burst read engine.
// Assumes one system clock for the configuration register and a host-made link clock for the pins.
package fbr_pkg;

	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam int CFG_W  = 16;
	localparam int BANK_POS = ADDR_W - 1;

	// Burst length codes that enable bursts; every other code leaves asynchronous reads only.
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;

	localparam logic [3:0] LEN_NONE = 4'h0;
	localparam logic [3:0] LEN_2    = 4'h2;
	localparam logic [3:0] LEN_4    = 4'h4;
	localparam logic [3:0] LEN_8    = 4'h8;

	typedef struct packed {
		logic       read_mode_select;
		logic       cfg_bit14;
		logic [3:0] initial_delay_code;
		logic       data_output_hold_cfg;
		logic       wait_timing_cfg;
		logic       burst_order_cfg;
		logic       clock_edge_cfg;
		logic [2:0] cfg_bits5_3;
		logic [2:0] burst_length_code;
	} fbr_cfg_t;

	// Asynchronous mode, delay 9 clocks, linear, rising edge, eight double words.
	localparam fbr_cfg_t CFG_RESET = 16'h9CC3;

	typedef struct packed {
		logic     rd_en;
		logic     bank;
		fbr_cfg_t cfg;
	} fbr_xfer_t;

	localparam fbr_xfer_t XFER_RESET = {1'b0, 1'b0, CFG_RESET};

	typedef struct packed {
		logic              ce_n;
		logic              oe_n;
		logic              adv_n;
		logic [ADDR_W-1:0] addr;
	} fbr_pins_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_DATA,
		ST_CFGRD,
		ST_ASYNC
	} fbr_state_t;

	localparam logic [3:0] WCNT_ZERO = 4'h0;
	localparam logic [2:0] BEAT_ZERO = 3'h0;
	localparam logic [15:0] UPPER_ZERO = 16'h0000;

endpackage

// ===== verilog/fbr_flash_burst.sv
// Burst read engine and burst configuration register of a 32-bit parallel flash.
// Assumes the host drives the pins synchronously to link_clk and the array answers combinationally.
// Functional notes
// - Burst returns 2, 4 or 8 words in group.
// - Order wraps modulo burst length from start.
// - Indicator low on final transfer before wrap.
// - Indicator floats unless output enable active.
// - Wait bit picks last or second-last transfer.
// - Reset ends burst, floats, restores configuration.
// - Chip select high leaves burst, floats data.
// - Address latched on first strobe-low clock edge.
// - New strobe drops old address, starts burst.
// - Output enable high floats data, burst continues.
// - Each burst word is held one clock.
// - Delay code plus two clocks to data.
// - Delay counts from latching edge; async unaffected.
// - Read-mode bit zero enables synchronous bursts.
// - Length codes 1..3 give 2,4,8 words.
// - Order and clock bits must be one.
// - Register defaults on reset, kept across deselect.
// - Register readable; writes ignored while algorithm busy.
// - Register on low lines, upper lines zero.
// - Latched bank returns register, other bank array.
// - Register reads are single-cycle, held while enabled.
module fbr_flash_burst
(
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     cfg_wr_valid,
	input  wire fbr_pkg::fbr_cfg_t        cfg_wr_data,
	input  wire logic                     algo_busy,
	input  wire logic                     cfg_read_cmd,
	input  wire logic                     cfg_read_bank,
	input  wire logic                     cfg_read_exit,
	output fbr_pkg::fbr_cfg_t             cfg_rd_data,
	input  wire logic                     link_clk,
	input  wire fbr_pkg::fbr_pins_t       flash_pins,
	output logic [fbr_pkg::ADDR_W-1:0]    array_rd_addr,
	input  wire logic [fbr_pkg::DATA_W-1:0] array_rd_data,
	output logic [fbr_pkg::DATA_W-1:0]    data_lines_o,
	output logic                          data_lines_oe,
	output logic                          end_of_burst_flag_n_o,
	output logic                          end_of_burst_flag_n_oe
);
	import fbr_pkg::*;

	function automatic logic [3:0] burst_len(input logic [2:0] code);
		logic [3:0] len;
		len = LEN_NONE;
		if (code == BL_CODE_2)
			len = LEN_2;
		else if (code == BL_CODE_4)
			len = LEN_4;
		else if (code == BL_CODE_8)
			len = LEN_8;
		return len;
	endfunction

	// Only the low three address bits move, so a burst can never leave its aligned group.
	function automatic logic [ADDR_W-1:0] wrap_next(input logic [ADDR_W-1:0] a, input logic [2:0] mask);
		logic [2:0] low;
		low = a[2:0] + 3'h1;
		return {a[ADDR_W-1:3], (a[2:0] & ~mask) | (low & mask)};
	endfunction

	// System clock side: the register itself and the sending half of the crossing.
	fbr_cfg_t  cfg_r;
	fbr_cfg_t  cfg_nxt;
	logic      rd_en_r;
	logic      rd_en_nxt;
	logic      bank_r;
	logic      bank_nxt;
	fbr_xfer_t snap_r;
	fbr_xfer_t snap_nxt;
	logic      req_r;
	logic      req_nxt;
	logic      ack_s1_r;
	logic      ack_s2_r;
	logic      ack_r;

	always_comb
	begin
		cfg_nxt   = cfg_r;
		rd_en_nxt = rd_en_r;
		bank_nxt  = bank_r;
		snap_nxt  = snap_r;
		req_nxt   = req_r;
		if (cfg_wr_valid && !algo_busy)
			cfg_nxt = cfg_wr_data;
		if (cfg_read_cmd)
		begin
			rd_en_nxt = 1'b1;
			bank_nxt  = cfg_read_bank;
		end
		else if (cfg_read_exit)
			rd_en_nxt = 1'b0;
		// A new word is only launched once the previous one was acknowledged, so snap_r is stable
		// whenever the link side samples it.
		if (req_r == ack_s2_r && {rd_en_r, bank_r, cfg_r} != snap_r)
		begin
			snap_nxt = {rd_en_r, bank_r, cfg_r};
			req_nxt  = ~req_r;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cfg_r    <= CFG_RESET;
			rd_en_r  <= 1'b0;
			bank_r   <= 1'b0;
			snap_r   <= XFER_RESET;
			req_r    <= 1'b0;
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
		end
		else
		begin
			cfg_r    <= cfg_nxt;
			rd_en_r  <= rd_en_nxt;
			bank_r   <= bank_nxt;
			snap_r   <= snap_nxt;
			req_r    <= req_nxt;
			ack_s1_r <= ack_r;
			ack_s2_r <= ack_s1_r;
		end
	end

	assign cfg_rd_data = cfg_r;

	a_cfg_wr_busy: assert property (@(posedge clock) disable iff (rst)
		(cfg_wr_valid && algo_busy) |=> (cfg_r == $past(cfg_r)))
		else $error("Configuration changed by a write during a busy algorithm.");

	// Deselecting the flash or reading it must never disturb the stored settings.
	a_cfg_keep: assert property (@(posedge clock) disable iff (rst)
		!cfg_wr_valid |=> (cfg_r == $past(cfg_r)))
		else $error("Configuration changed without a write.");

	// Link clock side: reset and configuration crossing.
	logic      lrst_s1_r;
	logic      lrst_s2_r;
	logic      req_s1_r;
	logic      req_s2_r;
	logic      ack_nxt;
	fbr_xfer_t lcfg_r;
	fbr_xfer_t lcfg_nxt;

	always_comb
	begin
		ack_nxt  = ack_r;
		lcfg_nxt = lcfg_r;
		if (req_s2_r != ack_r)
		begin
			lcfg_nxt = snap_r;
			ack_nxt  = req_s2_r;
		end
	end

	// The host must keep the link clock running through reset, or the link side never sees it.
	always_ff @(posedge link_clk)
	begin
		lrst_s1_r <= rst;
		lrst_s2_r <= lrst_s1_r;
		if (lrst_s2_r)
		begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			ack_r    <= 1'b0;
			lcfg_r   <= XFER_RESET;
		end
		else
		begin
			req_s1_r <= req_r;
			req_s2_r <= req_s1_r;
			ack_r    <= ack_nxt;
			lcfg_r   <= lcfg_nxt;
		end
	end

	// Burst engine.
	fbr_state_t        state_r;
	fbr_state_t        state_nxt;
	logic [3:0]        wcnt_r;
	logic [3:0]        wcnt_nxt;
	logic [2:0]        beat_r;
	logic [2:0]        beat_nxt;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic [DATA_W-1:0] dq_r;
	logic [DATA_W-1:0] dq_nxt;
	logic              dq_valid_r;
	logic              dq_valid_nxt;
	logic              eob_low_r;
	logic              eob_low_nxt;
	logic              adv_prev_r;
	logic [3:0]        len;
	logic [2:0]        mask;
	logic [2:0]        last_beat;
	logic              burst_ok;
	logic              start;
	logic              cfg_hit;
	logic              present;

	always_comb
	begin
		len       = burst_len(lcfg_r.cfg.burst_length_code);
		mask      = len[2:0] - 3'h1;
		// Second-to-last when the wait bit is set; with two words that is the first one.
		last_beat = lcfg_r.cfg.wait_timing_cfg ? mask - 3'h1 : mask;
		burst_ok  = !lcfg_r.cfg.read_mode_select && len != LEN_NONE
			&& lcfg_r.cfg.burst_order_cfg && lcfg_r.cfg.clock_edge_cfg;
		// Only the falling strobe starts a burst; a strobe held low does not relatch.
		start     = !flash_pins.ce_n && !flash_pins.adv_n && adv_prev_r;
		cfg_hit   = lcfg_r.rd_en && flash_pins.addr[BANK_POS] == lcfg_r.bank;
		present   = (state_r == ST_WAIT && wcnt_r == WCNT_ZERO) || state_r == ST_DATA;

		state_nxt    = state_r;
		wcnt_nxt     = wcnt_r;
		beat_nxt     = beat_r;
		addr_nxt     = addr_r;
		dq_nxt       = dq_r;
		dq_valid_nxt = dq_valid_r;
		eob_low_nxt  = 1'b0;

		if (flash_pins.ce_n)
		begin
			state_nxt    = ST_IDLE;
			dq_valid_nxt = 1'b0;
		end
		else if (start && cfg_hit)
		begin
			state_nxt    = ST_CFGRD;
			dq_nxt       = {UPPER_ZERO, lcfg_r.cfg};
			dq_valid_nxt = 1'b1;
		end
		else if (start && burst_ok)
		begin
			state_nxt    = ST_WAIT;
			wcnt_nxt     = lcfg_r.cfg.initial_delay_code;
			addr_nxt     = flash_pins.addr;
			beat_nxt     = BEAT_ZERO;
			dq_valid_nxt = 1'b0;
		end
		else if (present)
		begin
			state_nxt    = ST_DATA;
			dq_nxt       = array_rd_data;
			dq_valid_nxt = 1'b1;
			addr_nxt     = wrap_next(addr_r, mask);
			beat_nxt     = (beat_r + 3'h1) & mask;
			eob_low_nxt  = beat_r == last_beat;
		end
		else
		begin
			case (state_r)
				ST_WAIT:
					wcnt_nxt = wcnt_r - 4'h1;
				ST_IDLE, ST_ASYNC:
				begin
					// Plain reads track the pins; the burst delay plays no part here.
					if (!burst_ok && !start)
					begin
						state_nxt    = ST_ASYNC;
						addr_nxt     = flash_pins.addr;
						dq_nxt       = array_rd_data;
						dq_valid_nxt = state_r == ST_ASYNC;
					end
					else
						state_nxt = ST_IDLE;
				end
				default:
					state_nxt = state_r;
			endcase
		end
	end

	always_ff @(posedge link_clk)
	begin
		if (lrst_s2_r)
		begin
			state_r    <= ST_IDLE;
			wcnt_r     <= WCNT_ZERO;
			beat_r     <= BEAT_ZERO;
			addr_r     <= '0;
			dq_r       <= '0;
			dq_valid_r <= 1'b0;
			eob_low_r  <= 1'b0;
			adv_prev_r <= 1'b1;
		end
		else
		begin
			state_r    <= state_nxt;
			wcnt_r     <= wcnt_nxt;
			beat_r     <= beat_nxt;
			addr_r     <= addr_nxt;
			dq_r       <= dq_nxt;
			dq_valid_r <= dq_valid_nxt;
			eob_low_r  <= eob_low_nxt;
			adv_prev_r <= flash_pins.adv_n;
		end
	end

	// Output enable only gates the pins; the engine keeps stepping behind them.
	assign array_rd_addr          = addr_r;
	assign data_lines_o           = dq_r;
	assign data_lines_oe          = dq_valid_r && !flash_pins.ce_n && !flash_pins.oe_n
		&& !lrst_s2_r;
	assign end_of_burst_flag_n_o  = !eob_low_r;
	assign end_of_burst_flag_n_oe = !flash_pins.oe_n && !flash_pins.ce_n && !lrst_s2_r
		&& (state_r == ST_WAIT || state_r == ST_DATA);

	a_ce_float: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		flash_pins.ce_n |=> (flash_pins.ce_n |-> !data_lines_oe && state_r == ST_IDLE))
		else $error("Data lines driven or burst alive with chip select high.");

	a_oe_float: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		(flash_pins.oe_n && state_r == ST_DATA && !flash_pins.ce_n && !start)
		|=> state_r == ST_DATA && array_rd_addr != $past(array_rd_addr)
		&& (!data_lines_oe || !flash_pins.oe_n))
		else $error("Burst stalled or data driven while output enable is high.");

	a_eob_float: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		flash_pins.oe_n |-> !end_of_burst_flag_n_oe)
		else $error("End-of-burst flag driven while output enable is high.");

	a_delay_load: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		(start && burst_ok && !cfg_hit)
		|=> state_r == ST_WAIT && wcnt_r == $past(lcfg_r.cfg.initial_delay_code) && !dq_valid_r)
		else $error("Burst start did not load the initial delay.");

	a_first_data: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		(state_r == ST_WAIT && wcnt_r == WCNT_ZERO && !flash_pins.ce_n && !start)
		|=> state_r == ST_DATA && dq_valid_r && dq_r == $past(array_rd_data))
		else $error("First burst word not presented when the delay ran out.");

	a_group_stay: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		(state_r == ST_DATA && !flash_pins.ce_n && !start)
		|=> array_rd_addr[ADDR_W-1:3] == $past(array_rd_addr[ADDR_W-1:3]))
		else $error("Burst left its aligned group.");

	a_eob_pulse: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		(!end_of_burst_flag_n_o && len != LEN_2) |=> end_of_burst_flag_n_o)
		else $error("End-of-burst flag low for more than one clock.");

	a_cfg_upper: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		(start && cfg_hit) |=> state_r == ST_CFGRD && dq_r[DATA_W-1:CFG_W] == UPPER_ZERO
		&& dq_r[CFG_W-1:0] == $past(lcfg_r.cfg))
		else $error("Register read returned wrong data.");

	// Reset must leave the engine idle with nothing driven, whatever the pins do.
	a_reset_float: assert property (@(posedge link_clk)
		lrst_s2_r |=> state_r == ST_IDLE && !dq_valid_r && !eob_low_r)
		else $error("Burst engine not cleared by reset.");

	a_cfg_hold: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		(state_r == ST_CFGRD && !flash_pins.ce_n && !start)
		|=> state_r == ST_CFGRD && data_lines_o == $past(data_lines_o))
		else $error("Register read data not held.");

	a_eob_high: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		(state_r == ST_WAIT) |-> end_of_burst_flag_n_o)
		else $error("End-of-burst flag low before the first word.");

	// Plain reads follow the pins one edge later and never wait for the burst delay.
	a_async_track: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		(state_r == ST_ASYNC && !flash_pins.ce_n && !start && !burst_ok)
		|=> state_r == ST_ASYNC && array_rd_addr == $past(flash_pins.addr))
		else $error("Plain read did not follow the address pins.");

	a_restart_drop: assert property (@(posedge link_clk) disable iff (lrst_s2_r)
		(state_r == ST_DATA && start && burst_ok && !cfg_hit)
		|=> state_r == ST_WAIT && !dq_valid_r)
		else $error("Restarted burst kept presenting old data.");

endmodule
